// [src/slfc_params.svh]
// Constants for the store-to-load forward check
`ifndef SLFC_PARAMS_SVH
`define SLFC_PARAMS_SVH
`define SLFC_ADDR_W   32
`define SLFC_EADDR_W  33
`define SLFC_DATA_W   128
`define SLFC_ENTRIES  8
`define SLFC_IDX_W    3
`define SLFC_CNT_W    4
`define SLFC_SLOTS    4
`define SLFC_SLOT_W   2
`define SLFC_TAG_W    4
`define SLFC_OFF_W    4
`define SLFC_START1   3'h1
`define SLFC_START7   3'h7
`define SLFC_ONE_BYTE 5'h01
`endif

// [src/slfc_pkg.sv]
// Types for the store-to-load forward check
package slfc_pkg;
  typedef enum logic [2:0] {
    SZ8   = 3'b000,
    SZ16  = 3'b001,
    SZ32  = 3'b010,
    SZ64  = 3'b011,
    SZ128 = 3'b100
  } slfc_size_t;

  typedef enum logic [1:0] {
    FWD_NONE  = 2'b00,
    FWD_OK    = 2'b01,
    FWD_STALL = 2'b10
  } slfc_fwd_t;

  typedef enum logic [0:0] {
    DR_IDLE  = 1'b0,
    DR_WRITE = 1'b1
  } slfc_drain_t;
endpackage : slfc_pkg

// [src/slfc_store_mem.sv]
// Store buffer data array with two registered read ports
`timescale 1ns/100ps
`default_nettype none
`include "slfc_params.svh"
module slfc_store_mem (
  // Clock, reset and enable
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic                     ce,
  // Data write
  input  wire logic                     wr_en,
  input  wire logic [`SLFC_IDX_W-1:0]   wr_idx,
  input  wire logic [`SLFC_DATA_W-1:0]  wr_data,
  // Forward read, shifted down by a byte offset
  input  wire logic                     rd_a_en,
  input  wire logic [`SLFC_IDX_W-1:0]   rd_a_idx,
  input  wire logic [`SLFC_OFF_W-1:0]   rd_a_off,
  output var  logic [`SLFC_DATA_W-1:0]  rd_a_data,
  // Drain read
  input  wire logic                     rd_b_en,
  input  wire logic [`SLFC_IDX_W-1:0]   rd_b_idx,
  output var  logic [`SLFC_DATA_W-1:0]  rd_b_data
);
  logic [`SLFC_DATA_W-1:0] mem [`SLFC_ENTRIES];
  wire  [`SLFC_OFF_W+2:0]  shift_bits = {rd_a_off, 3'h0};

  always_ff @(posedge core_clk) begin
    if (ce && wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end else if (ce) begin
      if (rd_a_en) begin
        rd_a_data <= mem[rd_a_idx] >> shift_bits;
      end
      if (rd_b_en) begin
        rd_b_data <= mem[rd_b_idx];
      end
    end
  end
endmodule : slfc_store_mem
`default_nettype wire

// [src/slfc_forward_check.sv]
// Store buffer with store-to-load forwarding eligibility and load hold slots
// Overview of operation
// RULE1 - Forward only from same start address; aligned and start byte 7 32-bit stores also forward at nonzero offsets
// RULE2 - Forward only if load inside one store
// RULE3 - Hold forwarded load until store data arrives
// RULE4 - Ready younger loads pass blocked older loads
// RULE5 - Load spanning several stores waits for drain
// RULE6 - Narrow load at nonzero offset waits drain; byte loads from start byte 7 32-bit stores forward at any offset
// RULE7 - Aligned 16/32-bit store width and offset table
// RULE8 - Aligned 64-bit store width and offset table
// RULE9 - Aligned 128-bit store width and offset table
// RULE10 - Start byte 1 stores forward at start; 64-bit loads stall, and 128-bit stores forward only byte or 128-bit loads
// RULE11 - Start byte 7 stores mostly stall
// RULE12 - Refused load reads cache after store drains
// RULE13 - Stores drain only after retirement
// RULE14 - Youngest older overlapping store is the source
`timescale 1ns/100ps
`default_nettype none
`include "slfc_params.svh"
module slfc_forward_check
  import slfc_pkg::*;
(
  // Clock, reset and enable
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic                     ce,
  // Store allocation, in program order
  input  wire logic                     st_alloc_valid,
  input  wire logic [`SLFC_ADDR_W-1:0]  st_alloc_addr,
  input  wire slfc_size_t               st_alloc_size,
  output var  logic                     st_alloc_ready,
  output var  logic [`SLFC_IDX_W-1:0]   st_alloc_idx,
  // Store data
  input  wire logic                     st_data_valid,
  input  wire logic [`SLFC_IDX_W-1:0]   st_data_idx,
  input  wire logic [`SLFC_DATA_W-1:0]  st_data,
  // Store retirement
  input  wire logic                     st_retire,
  // Cache write
  output var  logic                     cache_wr_valid,
  output var  logic [`SLFC_ADDR_W-1:0]  cache_wr_addr,
  output var  slfc_size_t               cache_wr_size,
  output var  logic [`SLFC_DATA_W-1:0]  cache_wr_data,
  input  wire logic                     cache_wr_ready,
  // Load request
  input  wire logic                     ld_valid,
  input  wire logic [`SLFC_ADDR_W-1:0]  ld_addr,
  input  wire slfc_size_t               ld_size,
  input  wire logic [`SLFC_TAG_W-1:0]   ld_tag,
  output var  logic                     ld_ready,
  // Load answer
  output var  logic                     ld_resp_valid,
  output var  logic [`SLFC_TAG_W-1:0]   ld_resp_tag,
  output var  logic                     ld_resp_fwd,
  output var  logic [`SLFC_DATA_W-1:0]  ld_resp_data
);
  function automatic logic [4:0] nbytes(input slfc_size_t s);
    return `SLFC_ONE_BYTE << s;
  endfunction : nbytes
  function automatic slfc_fwd_t fwd_class(input logic [`SLFC_ADDR_W-1:0] sa, input slfc_size_t ss,
                                          input logic [`SLFC_ADDR_W-1:0] la, input slfc_size_t ls);
    logic [`SLFC_EADDR_W-1:0] s_end;
    logic [`SLFC_EADDR_W-1:0] l_end;
    logic [`SLFC_OFF_W-1:0]   off;
    logic [`SLFC_OFF_W-1:0]   amask;
    logic                     ok;
    slfc_fwd_t                r;
    s_end = {1'b0, sa} + `SLFC_EADDR_W'(nbytes(ss));
    l_end = {1'b0, la} + `SLFC_EADDR_W'(nbytes(ls));
    off   = la[`SLFC_OFF_W-1:0] - sa[`SLFC_OFF_W-1:0];
    amask = `SLFC_OFF_W'(nbytes(ss) - `SLFC_ONE_BYTE);
    if (ss == SZ8) begin
      ok = 1'b1;
    end else if ((sa[`SLFC_OFF_W-1:0] & amask) == '0) begin
      ok = (off == '0) || (ls == SZ32 && off[1:0] == '0) || (ls == SZ64 && off[2:0] == '0) // see RULE8 see RULE9
           || (ls == SZ16 && ss == SZ32 && off[0] == 1'b0);                                 // see RULE7 see RULE6
    end else if (sa[2:0] == `SLFC_START1 && (ss == SZ32 || ss == SZ64)) begin
      ok = (off == '0) && (ls != SZ64);                                                      // see RULE10 see RULE1
    end else if (sa[2:0] == `SLFC_START7 && ss == SZ32) begin
      ok = (ls == SZ8);                                                                      // see RULE11
    end else begin
      ok = (off == '0) && (ls == SZ8 || (ls == ss && sa[2:0] != `SLFC_START7));             // see RULE11 see RULE1
    end
    if ({1'b0, la} >= s_end || {1'b0, sa} >= l_end) begin
      r = FWD_NONE;
    end else if (la < sa || l_end > s_end) begin
      r = FWD_STALL;                                                                         // see RULE2 see RULE5
    end else begin
      r = ok ? FWD_OK : FWD_STALL;
    end
    return r;
  endfunction : fwd_class
  // Store buffer entries
  logic [`SLFC_ENTRIES-1:0] ent_vld;
  logic [`SLFC_ENTRIES-1:0] ent_dvld;
  logic [`SLFC_ENTRIES-1:0] ent_ret;
  logic [`SLFC_ADDR_W-1:0]  ent_addr [`SLFC_ENTRIES];
  slfc_size_t               ent_size [`SLFC_ENTRIES];
  logic [`SLFC_IDX_W-1:0]   head_reg;
  logic [`SLFC_IDX_W-1:0]   tail_reg;
  logic [`SLFC_IDX_W-1:0]   ret_reg;
  logic [`SLFC_CNT_W-1:0]   cnt_reg;
  slfc_drain_t              drain_reg;
  // Load hold slots
  logic [`SLFC_SLOTS-1:0]   lq_vld;
  logic [`SLFC_ADDR_W-1:0]  lq_addr [`SLFC_SLOTS];
  slfc_size_t               lq_size [`SLFC_SLOTS];
  logic [`SLFC_TAG_W-1:0]   lq_tag  [`SLFC_SLOTS];
  logic [`SLFC_ENTRIES-1:0] lq_old  [`SLFC_SLOTS];
  // Per-slot evaluation
  logic [`SLFC_SLOTS-1:0]   found;
  logic [`SLFC_IDX_W-1:0]   src     [`SLFC_SLOTS];
  slfc_fwd_t                cls     [`SLFC_SLOTS];
  logic [`SLFC_SLOTS-1:0]   go;
  logic                     sel_valid;
  logic [`SLFC_SLOT_W-1:0]  sel_slot;
  logic [`SLFC_SLOT_W-1:0]  acc_slot;
  wire alloc_go   = st_alloc_valid && st_alloc_ready;
  wire load_go    = ld_valid && ld_ready;
  wire drain_req  = ent_vld[head_reg] && ent_ret[head_reg] && ent_dvld[head_reg] && drain_reg == DR_IDLE; // see RULE13
  wire drain_free = drain_reg == DR_WRITE && cache_wr_ready;
  wire [`SLFC_ENTRIES-1:0] alloc_hot = alloc_go ? `SLFC_ENTRIES'(1) << tail_reg : '0;
  wire [`SLFC_ENTRIES-1:0] free_hot  = drain_free ? `SLFC_ENTRIES'(1) << head_reg : '0;
  wire [`SLFC_SLOTS-1:0]   sel_hot   = sel_valid ? `SLFC_SLOTS'(1) << sel_slot : '0;
  wire [`SLFC_SLOTS-1:0]   acc_hot   = load_go ? `SLFC_SLOTS'(1) << acc_slot : '0;
  wire [`SLFC_SLOTS-1:0]   lq_vld_next = (lq_vld & ~sel_hot) | acc_hot;
  wire [`SLFC_CNT_W-1:0]   cnt_next  = cnt_reg + `SLFC_CNT_W'(alloc_go) - `SLFC_CNT_W'(drain_free);
  // Selected slot view
  wire [`SLFC_IDX_W-1:0]   sel_src    = src[sel_slot];
  wire                     sel_fwd    = found[sel_slot];
  wire                     sel_fwd_go = sel_valid && sel_fwd;
  wire [`SLFC_ADDR_W-1:0]  sel_st_addr = ent_addr[sel_src];
  wire slfc_size_t         sel_st_size = ent_size[sel_src];
  wire [`SLFC_ADDR_W-1:0]  sel_ld_addr = lq_addr[sel_slot];
  wire slfc_size_t         sel_ld_size = lq_size[sel_slot];
  wire [`SLFC_TAG_W-1:0]   sel_tag     = lq_tag[sel_slot];
  wire [`SLFC_OFF_W-1:0]   sel_off     = sel_ld_addr[`SLFC_OFF_W-1:0] - sel_st_addr[`SLFC_OFF_W-1:0];
  // Youngest older overlapping store decides each held load
  always_comb begin
    logic [`SLFC_IDX_W-1:0] k;
    slfc_fwd_t              c;
    k = '0;
    c = FWD_NONE;
    for (int s = 0; s < `SLFC_SLOTS; s++) begin
      found[s] = 1'b0;
      src[s]   = '0;
      cls[s]   = FWD_NONE;
      for (int i = 0; i < `SLFC_ENTRIES; i++) begin
        k = head_reg + `SLFC_IDX_W'(i);
        c = fwd_class(ent_addr[k], ent_size[k], lq_addr[s], lq_size[s]);
        if (lq_old[s][k] && ent_vld[k] && c != FWD_NONE) begin
          found[s] = 1'b1;                                                 // see RULE14
          src[s]   = k;
          cls[s]   = c;
        end
      end
      go[s] = lq_vld[s] && (!found[s] || (cls[s] == FWD_OK && ent_dvld[src[s]])); // see RULE3 see RULE12
    end
  end
  // Lowest ready slot completes, whatever its age
  always_comb begin
    sel_valid = 1'b0;
    sel_slot  = '0;
    acc_slot  = '0;
    for (int s = `SLFC_SLOTS - 1; s >= 0; s--) begin
      if (go[s]) begin
        sel_valid = 1'b1;                                                  // see RULE4
        sel_slot  = `SLFC_SLOT_W'(s);
      end
      if (!lq_vld[s]) begin
        acc_slot = `SLFC_SLOT_W'(s);
      end
    end
  end
  slfc_store_mem u_mem (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .wr_en     (st_data_valid),
    .wr_idx    (st_data_idx),
    .wr_data   (st_data),
    .rd_a_en   (sel_fwd_go),
    .rd_a_idx  (sel_src),
    .rd_a_off  (sel_off),
    .rd_a_data (ld_resp_data),
    .rd_b_en   (drain_req),
    .rd_b_idx  (head_reg),
    .rd_b_data (cache_wr_data)
  );
  assign st_alloc_idx = tail_reg;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ent_vld <= '0;
      ent_dvld <= '0;
      ent_ret <= '0;
      head_reg <= '0;
      tail_reg <= '0;
      ret_reg <= '0;
      cnt_reg <= '0;
      st_alloc_ready <= 1'b0;
      drain_reg <= DR_IDLE;
      cache_wr_valid <= 1'b0;
      cache_wr_addr <= '0;
      cache_wr_size <= SZ8;
    end else if (ce) begin
      if (alloc_go) begin
        ent_vld[tail_reg] <= 1'b1;
        ent_dvld[tail_reg] <= 1'b0;
        ent_ret[tail_reg] <= 1'b0;
        ent_addr[tail_reg] <= st_alloc_addr;
        ent_size[tail_reg] <= st_alloc_size;
        tail_reg <= tail_reg + 1'b1;
      end
      if (st_data_valid) begin
        ent_dvld[st_data_idx] <= 1'b1;
      end
      if (st_retire) begin
        ent_ret[ret_reg] <= 1'b1;
        ret_reg <= ret_reg + 1'b1;
      end
      if (drain_req) begin
        drain_reg <= DR_WRITE;                                             // see RULE13
        cache_wr_valid <= 1'b1;
        cache_wr_addr <= ent_addr[head_reg];
        cache_wr_size <= ent_size[head_reg];
      end
      if (drain_free) begin
        drain_reg <= DR_IDLE;
        cache_wr_valid <= 1'b0;
        ent_vld[head_reg] <= 1'b0;
        head_reg <= head_reg + 1'b1;
      end
      cnt_reg <= cnt_next;
      st_alloc_ready <= cnt_next < `SLFC_CNT_W'(`SLFC_ENTRIES);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lq_vld <= '0;
      ld_ready <= 1'b0;
      ld_resp_valid <= 1'b0;
      ld_resp_tag <= '0;
      ld_resp_fwd <= 1'b0;
      for (int s = 0; s < `SLFC_SLOTS; s++) begin
        lq_old[s] <= '0;
      end
    end else if (ce) begin
      lq_vld <= lq_vld_next;
      ld_ready <= ~&lq_vld_next;
      ld_resp_valid <= sel_valid;
      ld_resp_tag <= sel_tag;
      ld_resp_fwd <= sel_fwd_go;
      for (int s = 0; s < `SLFC_SLOTS; s++) begin
        lq_old[s] <= lq_old[s] & ~free_hot;                                // see RULE12
      end
      if (load_go) begin
        lq_addr[acc_slot] <= ld_addr;
        lq_size[acc_slot] <= ld_size;
        lq_tag[acc_slot] <= ld_tag;
        lq_old[acc_slot] <= (ent_vld | alloc_hot) & ~free_hot;
      end
    end
  end

  a_same_start: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE1
    sel_fwd_go && sel_st_addr[2:0] == `SLFC_START1 && sel_st_size inside {SZ32, SZ64} |-> sel_off == '0)
    else $error("start byte 1 store forwarded at nonzero offset");
  a_load_contained: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE2 see RULE5
    sel_fwd_go |-> sel_ld_addr >= sel_st_addr
      && {1'b0, sel_ld_addr} + `SLFC_EADDR_W'(nbytes(sel_ld_size)) <= {1'b0, sel_st_addr} + `SLFC_EADDR_W'(nbytes(sel_st_size)))
    else $error("forwarded load not inside its store");
  a_data_present: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE3
    sel_fwd_go && ce |-> ent_dvld[sel_src] ##1 (ld_resp_valid && ld_resp_fwd))
    else $error("load forwarded before store data arrived");
  a_pass_blocked: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE4
    sel_valid && ce |=> ld_resp_valid && ld_resp_tag == $past(sel_tag))
    else $error("ready load did not complete next cycle");
  a_narrow_offset: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE6
    sel_fwd_go && sel_ld_size == SZ8 && sel_st_size != SZ8 && sel_st_addr[2:0] != `SLFC_START7 |-> sel_off == '0)
    else $error("byte load forwarded at nonzero offset");
  a_st16_offset: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE7
    sel_fwd_go && sel_st_size == SZ16 |-> sel_off == '0)
    else $error("word store forwarded at odd byte");
  a_st64_dword: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE8
    sel_fwd_go && sel_st_size == SZ64 && sel_ld_size == SZ32 |-> sel_off[1:0] == '0)
    else $error("dword load forwarded misaligned from qword store");
  a_st128_qword: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE9
    sel_fwd_go && sel_st_size == SZ128 && sel_ld_size == SZ64 |-> sel_off[2:0] == '0)
    else $error("qword load forwarded misaligned from dqword store");
  a_start7_byte: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE11
    sel_fwd_go && sel_st_addr[2:0] == `SLFC_START7 && sel_st_size != SZ8 |-> sel_ld_size == SZ8)
    else $error("wide load forwarded from start byte 7 store");
  a_drain_retired: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE13
    cache_wr_valid |-> ent_vld[head_reg] && ent_ret[head_reg])
    else $error("unretired store written to cache");
endmodule : slfc_forward_check
`default_nettype wire

// [tb/slfc_cache_model.sv]
// Cache write port model that accepts writes promptly or after a stall
`timescale 1ns/100ps
`default_nettype none
module slfc_cache_model
  import slfc_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Cache write handshake
  input  wire logic       cache_wr_valid,
  output var  logic       cache_wr_ready,
  // Pace select and write count
  input  wire logic       slow,
  output var  logic [7:0] wr_count
);
  logic [1:0] wait_reg;

  // Slow mode holds off acceptance for three cycles
  assign cache_wr_ready = cache_wr_valid && (!slow || wait_reg == 2'h3);

  always_ff @(posedge core_clk) begin
    if (!reset_n || !cache_wr_valid || cache_wr_ready) begin
      wait_reg <= 2'h0;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
    if (!reset_n) begin
      wr_count <= 8'h00;
    end else if (cache_wr_ready) begin
      wr_count <= wr_count + 8'h01;
    end
  end
endmodule : slfc_cache_model
`default_nettype wire

// [tb/tb_store_load_forward_check.sv]
// Self-checking bench for the store-to-load forward check
`timescale 1ns/100ps
`default_nettype none
`include "slfc_params.svh"
module tb_store_load_forward_check import slfc_pkg::*;;
  logic                      core_clk = 1'b0;
  logic                      reset_n, ce, slow;
  logic                      st_alloc_valid, st_alloc_ready, st_data_valid, st_retire;
  logic                      cache_wr_valid, cache_wr_ready, ld_valid, ld_ready;
  logic                      ld_resp_valid, ld_resp_fwd;
  logic [`SLFC_ADDR_W-1:0]   st_alloc_addr, cache_wr_addr, ld_addr;
  logic [`SLFC_IDX_W-1:0]    st_alloc_idx, st_data_idx;
  logic [`SLFC_DATA_W-1:0]   st_data, cache_wr_data, ld_resp_data;
  logic [`SLFC_TAG_W-1:0]    ld_tag, ld_resp_tag;
  logic [7:0]                wr_count;
  slfc_size_t                st_alloc_size, cache_wr_size, ld_size;
  int                        checks = 0;
  int                        bad_count = 0;
  int                        n_st = 0;
  logic [`SLFC_ADDR_W-1:0]   seen_addr;
  logic [`SLFC_DATA_W-1:0]   seen_data;
  slfc_size_t                seen_size;

  always #5 core_clk = ~core_clk;

  // Last write the cache accepted
  always @(posedge core_clk) begin
    if (cache_wr_valid && cache_wr_ready) begin
      seen_addr <= cache_wr_addr;
      seen_size <= cache_wr_size;
      seen_data <= cache_wr_data;
    end
  end

  slfc_forward_check dut (.core_clk(core_clk), .reset_n(reset_n), .ce(ce), .st_alloc_valid(st_alloc_valid),
    .st_alloc_addr(st_alloc_addr), .st_alloc_size(st_alloc_size), .st_alloc_ready(st_alloc_ready),
    .st_alloc_idx(st_alloc_idx), .st_data_valid(st_data_valid), .st_data_idx(st_data_idx), .st_data(st_data),
    .st_retire(st_retire), .cache_wr_valid(cache_wr_valid), .cache_wr_addr(cache_wr_addr),
    .cache_wr_size(cache_wr_size), .cache_wr_data(cache_wr_data), .cache_wr_ready(cache_wr_ready),
    .ld_valid(ld_valid), .ld_addr(ld_addr), .ld_size(ld_size), .ld_tag(ld_tag), .ld_ready(ld_ready),
    .ld_resp_valid(ld_resp_valid), .ld_resp_tag(ld_resp_tag), .ld_resp_fwd(ld_resp_fwd),
    .ld_resp_data(ld_resp_data));

  slfc_cache_model cache (.core_clk(core_clk), .reset_n(reset_n), .cache_wr_valid(cache_wr_valid),
    .cache_wr_ready(cache_wr_ready), .slow(slow), .wr_count(wr_count));

  task automatic chk(input string what, input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic send_data(input logic [2:0] k, input logic [127:0] d);
    st_data_valid = 1'b1;
    st_data_idx = k;
    st_data = d;
    @(negedge core_clk);
    st_data_valid = 1'b0;
  endtask : send_data

  task automatic store(input logic [31:0] a, input slfc_size_t s, input logic [127:0] d, input bit wd,
                       output logic [2:0] k);
    @(negedge core_clk);
    chk("st_alloc_ready", st_alloc_ready, 1'b1);
    st_alloc_valid = 1'b1;
    st_alloc_addr = a;
    st_alloc_size = s;
    k = st_alloc_idx;
    @(negedge core_clk);
    st_alloc_valid = 1'b0;
    n_st++;
    if (wd) begin
      send_data(k, d);
    end
  endtask : store

  task automatic load(input logic [31:0] a, input slfc_size_t s, input logic [3:0] t);
    @(negedge core_clk);
    chk("ld_ready", ld_ready, 1'b1);
    ld_valid = 1'b1;
    ld_addr = a;
    ld_size = s;
    ld_tag = t;
    @(negedge core_clk);
    ld_valid = 1'b0;
  endtask : load

  task automatic retire(input int n);
    repeat (n) begin
      st_retire = 1'b1;
      @(negedge core_clk);
    end
    st_retire = 1'b0;
  endtask : retire

  task automatic expect_resp(input logic [3:0] t, input logic f, input logic [127:0] d, input int nb);
    int i = 0;
    logic [127:0] m;
    m = (nb >= 16) ? '1 : (128'h1 << (8 * nb)) - 128'h1;
    while (ld_resp_valid !== 1'b1 && i < 40) begin
      @(negedge core_clk);
      i++;
    end
    chk("resp_valid", ld_resp_valid, 1'b1);
    chk("resp_tag", ld_resp_tag, t);
    chk("resp_fwd", ld_resp_fwd, f);
    if (f) begin
      chk("resp_data", ld_resp_data & m, d & m);
    end
    @(negedge core_clk);
  endtask : expect_resp

  // No answer and no cache write for n cycles
  task automatic quiet(input int n);
    logic [7:0] w;
    w = wr_count;
    repeat (n) begin
      @(negedge core_clk);
      chk("no_resp", ld_resp_valid, 1'b0);
      chk("no_drain", wr_count, w);
    end
  endtask : quiet

  task automatic settle();
    int i = 0;
    while (wr_count !== n_st[7:0] && i < 100) begin
      @(negedge core_clk);
      i++;
    end
    chk("drained", wr_count, n_st[7:0]);
  endtask : settle

  task automatic table_case(input int c, input slfc_size_t ss, input logic [2:0] so, input slfc_size_t ls,
                            input logic [3:0] lo, input logic f);
    logic [127:0] d;
    logic [2:0] k;
    logic [31:0] a;
    slow = c[0];
    a = 32'h1000 + so;
    d = 128'h00112233445566778899aabbccddeeff ^ {16{c[7:0]}};
    store(a, ss, d, 1'b1, k);
    load(a + lo, ls, c[3:0]);
    if (!f) begin
      quiet(10);
      retire(1);
      expect_resp(c[3:0], 1'b0, '0, 0);
    end else begin
      expect_resp(c[3:0], 1'b1, d >> (8 * lo), 1 << ls);
      retire(1);
    end
    settle();
    chk("cache_addr", seen_addr, a);
    chk("cache_size", seen_size, ss);
    chk("cache_data", seen_data, d);
  endtask : table_case

  task automatic test_spanning();
    logic [2:0] k;
    for (int i = 0; i < 4; i++) begin
      store(32'h2000 + i, SZ8, 128'h41 + i, 1'b1, k);
    end
    load(32'h2000, SZ32, 4'h5);
    quiet(10);
    retire(4);
    expect_resp(4'h5, 1'b0, '0, 0);
    chk("drained_first", wr_count, n_st[7:0]);
    settle();
    $display("spanning stores test done");
  endtask : test_spanning

  task automatic test_overtake();
    logic [2:0] k;
    slow = 1'b1;
    store(32'h3000, SZ32, 128'h11223344, 1'b1, k);
    load(32'h3001, SZ8, 4'h1);
    load(32'h3000, SZ8, 4'h2);
    expect_resp(4'h2, 1'b1, 128'h44, 1);
    retire(1);
    expect_resp(4'h1, 1'b0, '0, 0);
    settle();
    $display("overtake test done");
  endtask : test_overtake

  task automatic test_data_wait();
    logic [2:0] k;
    slow = 1'b0;
    store(32'h4000, SZ32, '0, 1'b0, k);
    load(32'h4000, SZ32, 4'h3);
    load(32'h5000, SZ32, 4'h4);
    expect_resp(4'h4, 1'b0, '0, 0);
    quiet(6);
    ce = 1'b0;
    send_data(k, 128'h5a6b7c8d);
    quiet(4);
    ce = 1'b1;
    send_data(k, 128'h5a6b7c8d);
    expect_resp(4'h3, 1'b1, 128'h5a6b7c8d, 4);
    retire(1);
    settle();
    $display("data wait test done");
  endtask : test_data_wait

  task automatic test_youngest();
    logic [2:0] k;
    store(32'h6000, SZ32, 128'h01020304, 1'b1, k);
    store(32'h6000, SZ32, 128'ha0b0c0d0, 1'b1, k);
    load(32'h6000, SZ32, 4'h6);
    expect_resp(4'h6, 1'b1, 128'ha0b0c0d0, 4);
    retire(2);
    settle();
    $display("youngest store test done");
  endtask : test_youngest

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    {reset_n, st_alloc_valid, st_data_valid, st_retire, ld_valid, slow} = '0;
    ce = 1'b1;
    st_alloc_addr = '0;
    st_alloc_size = SZ8;
    st_data_idx = '0;
    st_data = '0;
    ld_addr = '0;
    ld_size = SZ8;
    ld_tag = '0;
    repeat (6) @(negedge core_clk);
    chk("reset_ready", {st_alloc_ready, ld_ready}, 2'b00);
    reset_n = 1'b1;
    @(negedge core_clk);
    table_case(1, SZ16, 3'h0, SZ8, 4'h0, 1'b1);
    table_case(2, SZ16, 3'h0, SZ8, 4'h1, 1'b0);
    table_case(3, SZ32, 3'h0, SZ32, 4'h0, 1'b1);
    table_case(4, SZ32, 3'h0, SZ16, 4'h2, 1'b1);
    table_case(5, SZ32, 3'h0, SZ8, 4'h2, 1'b0);
    table_case(6, SZ32, 3'h0, SZ16, 4'h1, 1'b0);
    table_case(7, SZ16, 3'h0, SZ32, 4'h0, 1'b0);
    table_case(8, SZ64, 3'h0, SZ16, 4'h0, 1'b1);
    table_case(9, SZ64, 3'h0, SZ32, 4'h4, 1'b1);
    table_case(10, SZ64, 3'h0, SZ32, 4'h2, 1'b0);
    table_case(11, SZ64, 3'h0, SZ8, 4'h4, 1'b0);
    table_case(12, SZ128, 3'h0, SZ64, 4'h8, 1'b1);
    table_case(13, SZ128, 3'h0, SZ128, 4'h0, 1'b1);
    table_case(14, SZ128, 3'h0, SZ64, 4'h4, 1'b0);
    table_case(15, SZ128, 3'h0, SZ32, 4'hc, 1'b1);
    table_case(16, SZ32, 3'h1, SZ16, 4'h0, 1'b1);
    table_case(17, SZ32, 3'h1, SZ8, 4'h1, 1'b0);
    table_case(18, SZ64, 3'h1, SZ32, 4'h0, 1'b1);
    table_case(19, SZ64, 3'h1, SZ64, 4'h0, 1'b0);
    table_case(20, SZ32, 3'h7, SZ8, 4'h2, 1'b1);
    table_case(21, SZ32, 3'h7, SZ16, 4'h0, 1'b0);
    table_case(22, SZ64, 3'h7, SZ32, 4'h0, 1'b0);
    $display("width and offset table test done");
    test_spanning();
    test_overtake();
    test_data_wait();
    test_youngest();
    tally_and_finish();
  end
endmodule : tb_store_load_forward_check
`default_nettype wire
